// File: hdl/uart_msfc.sv
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
module uart_msfc #(
	parameter int LEVEL_W = 7
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire uart_msfc_pkg::modem_in_t modem_pins,
	input wire logic [LEVEL_W-1:0] rx_level,
	input wire logic [LEVEL_W-1:0] trig_level,
	input wire logic [LEVEL_W-1:0] next_trig_level,
	input wire logic [LEVEL_W-1:0] lower_trig_level,
	input wire logic char_done,
	output logic tx_enable,
	output logic tx_out,
	output logic rts_n,
	output logic dtr_n,
	output logic receive_ready_out,
	output logic transmit_ready_out,
	output logic irq
);
	logic [7:0] scratch_reg;
	logic [7:0] enhanced_feature_reg;
	logic [7:0] modem_control_reg;
	logic [7:0] interrupt_enable_reg;
	logic [7:0] line_control_reg;
	logic [7:0] fifo_control_reg;
	logic [7:0] int_mask;
	logic [1:0] int_status;
	logic [7:0] modem_status_reg;
	logic [7:0] interrupt_ident_reg;
	logic [7:0] line_status_reg;
	logic trigger_hit;
	logic trig_prev;
	logic ms_read;
	logic st_read;
	logic modem_event;
	logic tx_stopped;
	logic aw_held;
	logic w_held;
	uart_msfc_pkg::bus_word_t wr;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic [1:0] next_status;
	modem_delta modem_delta_inst (
		.ref_clk(ref_clk),
		.reset(reset),
		.pins(modem_pins),
		.status_read(ms_read),
		.status(modem_status_reg)
	);
	rts_flow #(.LEVEL_W(LEVEL_W)) rts_flow_inst (
		.ref_clk(ref_clk),
		.reset(reset),
		.auto_rts(enhanced_feature_reg[uart_msfc_pkg::FEAT_AUTO_RTS]),
		.mcr_rts(modem_control_reg[uart_msfc_pkg::MCR_RTS]),
		.rx_level(rx_level),
		.trig_level(trig_level),
		.next_trig_level(next_trig_level),
		.lower_trig_level(lower_trig_level),
		.trigger_hit(trigger_hit),
		.rts_n(rts_n)
	);
	// write channel: accept address and data in either order
	assign awready = !aw_held && !bvalid;
	assign wready = !w_held && !bvalid;
	assign arready = !rvalid;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr <= '0;
			bvalid <= 1'b0;
			bresp <= uart_msfc_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				wr.addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				wr.data <= wdata;
			end
			if (aw_held && w_held) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				bresp <= uart_msfc_pkg::RESP_OKAY;
				case (wr.addr[7:0])
					uart_msfc_pkg::OFF_SCRATCH, uart_msfc_pkg::OFF_FEATURE,
					uart_msfc_pkg::OFF_MODEM_CONTROL, uart_msfc_pkg::OFF_INT_MASK,
					uart_msfc_pkg::OFF_INT_ENABLE, uart_msfc_pkg::OFF_LINE_CONTROL,
					uart_msfc_pkg::OFF_FIFO_CONTROL, uart_msfc_pkg::OFF_MODEM_STATUS,
					uart_msfc_pkg::OFF_INT_STATUS, uart_msfc_pkg::OFF_IDENT,
					uart_msfc_pkg::OFF_LINE_STATUS: ;
					default: bresp <= uart_msfc_pkg::RESP_SLVERR;
				endcase
				if (wr.addr[31:8] != 24'h0)
					bresp <= uart_msfc_pkg::RESP_SLVERR;
			end else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end
	logic wr_go;
	logic wstrb_ok;
	// byte lane 0 off: answered okay but nothing changes
	assign wr_go = aw_held && w_held && wstrb_ok && wr.addr[31:8] == 24'h0;
	logic strb0;
	always_ff @(posedge ref_clk) begin
		if (reset)
			strb0 <= 1'b0;
		else if (wvalid && wready)
			strb0 <= wstrb[0];
	end
	assign wstrb_ok = strb0;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			scratch_reg <= uart_msfc_pkg::CTRL_RESET;
			enhanced_feature_reg <= uart_msfc_pkg::CTRL_RESET;
			modem_control_reg <= uart_msfc_pkg::CTRL_RESET;
			interrupt_enable_reg <= uart_msfc_pkg::CTRL_RESET;
			line_control_reg <= uart_msfc_pkg::CTRL_RESET;
			fifo_control_reg <= uart_msfc_pkg::CTRL_RESET;
			int_mask <= uart_msfc_pkg::CTRL_RESET;
		end else if (wr_go) begin
			unique case (wr.addr[7:0])
				uart_msfc_pkg::OFF_SCRATCH:
					scratch_reg <= wr.data[7:0];
				uart_msfc_pkg::OFF_FEATURE:
					enhanced_feature_reg <= wr.data[7:0]
						& uart_msfc_pkg::FEATURE_RESERVED_MASK;
				uart_msfc_pkg::OFF_MODEM_CONTROL:
					modem_control_reg <= wr.data[7:0];
				uart_msfc_pkg::OFF_INT_MASK:
					int_mask <= wr.data[7:0];
				uart_msfc_pkg::OFF_INT_ENABLE:
					interrupt_enable_reg <= wr.data[7:0];
				uart_msfc_pkg::OFF_LINE_CONTROL:
					line_control_reg <= wr.data[7:0];
				uart_msfc_pkg::OFF_FIFO_CONTROL:
					fifo_control_reg <= wr.data[7:0];
				default: ;
			endcase
		end
	end
	// read channel
	assign ms_read = arvalid && arready
		&& araddr == {24'h0, uart_msfc_pkg::OFF_MODEM_STATUS};
	assign st_read = arvalid && arready
		&& araddr == {24'h0, uart_msfc_pkg::OFF_INT_STATUS};
	always_comb begin
		next_rresp = uart_msfc_pkg::RESP_OKAY;
		next_rdata = 32'h0;
		if (araddr[31:8] != 24'h0)
			next_rresp = uart_msfc_pkg::RESP_SLVERR;
		else
			case (araddr[7:0])
				uart_msfc_pkg::OFF_MODEM_STATUS: next_rdata = {24'h0, modem_status_reg};
				uart_msfc_pkg::OFF_SCRATCH: next_rdata = {24'h0, scratch_reg};
				uart_msfc_pkg::OFF_FEATURE: next_rdata = {24'h0, enhanced_feature_reg};
				uart_msfc_pkg::OFF_MODEM_CONTROL: next_rdata = {24'h0, modem_control_reg};
				uart_msfc_pkg::OFF_INT_STATUS: next_rdata = {30'h0, int_status};
				uart_msfc_pkg::OFF_INT_MASK: next_rdata = {24'h0, int_mask};
				uart_msfc_pkg::OFF_IDENT: next_rdata = {24'h0, interrupt_ident_reg};
				uart_msfc_pkg::OFF_LINE_STATUS: next_rdata = {24'h0, line_status_reg};
				uart_msfc_pkg::OFF_INT_ENABLE: next_rdata = {24'h0, interrupt_enable_reg};
				uart_msfc_pkg::OFF_LINE_CONTROL: next_rdata = {24'h0, line_control_reg};
				uart_msfc_pkg::OFF_FIFO_CONTROL: next_rdata = {24'h0, fifo_control_reg};
				default: next_rresp = uart_msfc_pkg::RESP_SLVERR;
			endcase
	end
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= uart_msfc_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end else if (rready)
			rvalid <= 1'b0;
	end
	// events: sticky status, set wins over read clear
	assign modem_event = |modem_status_reg[3:0];
	always_comb begin
		next_status = st_read ? 2'b00 : int_status;
		if (modem_event)
			next_status[uart_msfc_pkg::EV_MODEM] = 1'b1;
		if (trigger_hit && !trig_prev)
			next_status[uart_msfc_pkg::EV_TRIGGER] = 1'b1;
	end
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			int_status <= 2'b00;
			trig_prev <= 1'b0;
		end else begin
			int_status <= next_status;
			trig_prev <= trigger_hit;
		end
	end
	// line status is a fixed view in this slice; ident reads 00 while an unmasked event is pending
	assign interrupt_ident_reg = (|(int_status & int_mask[1:0]))
		? 8'h00 : uart_msfc_pkg::IDENT_RESET;
	assign line_status_reg = uart_msfc_pkg::LINE_STATUS_RESET;
	assign irq = |(int_status & int_mask[1:0]);
	// stop only between characters so a frame is never cut
	always_ff @(posedge ref_clk) begin
		if (reset)
			tx_stopped <= 1'b0;
		else if (!enhanced_feature_reg[uart_msfc_pkg::FEAT_AUTO_CTS])
			tx_stopped <= 1'b0;
		else if (!modem_pins.cts_n)
			tx_stopped <= 1'b0;
		else if (char_done || !tx_enable)
			tx_stopped <= 1'b1;
	end
	assign tx_enable = !tx_stopped;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tx_out <= 1'b1;
			dtr_n <= 1'b1;
			receive_ready_out <= 1'b1;
			transmit_ready_out <= 1'b0;
		end else begin
			tx_out <= 1'b1;
			dtr_n <= ~modem_control_reg[uart_msfc_pkg::MCR_DTR];
			receive_ready_out <= 1'b1;
			transmit_ready_out <= 1'b0;
		end
	end
	AST_IRQ_MODEM: assert property (@(posedge ref_clk) disable iff (reset)
		modem_event && int_mask[0] |=> irq)
		else $error("modem interrupt missing");
	AST_CTS_STOP: assert property (@(posedge ref_clk) disable iff (reset)
		enhanced_feature_reg[7] && modem_pins.cts_n && char_done
		|=> !tx_enable)
		else $error("transmitter not stopped");
	AST_CTS_RESUME: assert property (@(posedge ref_clk) disable iff (reset)
		!modem_pins.cts_n |=> tx_enable)
		else $error("transmitter not resumed");
	AST_RESET_STATE: assert property (@(posedge ref_clk)
		$past(reset) |-> rts_n && tx_out && !irq
		&& enhanced_feature_reg == 8'h00 && modem_status_reg[3:0] == 4'h0)
		else $error("reset state wrong");
	AST_SCRATCH: assert property (@(posedge ref_clk) disable iff (reset)
		wr_go && wr.addr[7:0] == 8'h04 |=> scratch_reg == $past(wr.data[7:0]))
		else $error("scratch not stored");
	AST_IDENT: assert property (@(posedge ref_clk) disable iff (reset)
		!irq |-> interrupt_ident_reg == 8'h01 && line_status_reg == 8'h60)
		else $error("ident or line status wrong");
	AST_IDENT_PEND: assert property (@(posedge ref_clk) disable iff (reset)
		irq |-> interrupt_ident_reg == 8'h00)
		else $error("ident shows no pending");
	AST_LINE_FIXED: assert property (@(posedge ref_clk) disable iff (reset)
		line_status_reg == uart_msfc_pkg::LINE_STATUS_RESET)
		else $error("line status moved");
	AST_RESET_PINS: assert property (@(posedge ref_clk)
		$past(reset) |-> dtr_n && receive_ready_out && !transmit_ready_out)
		else $error("reset pin levels wrong");
	AST_CTL_RESET: assert property (@(posedge ref_clk)
		$past(reset) |-> modem_control_reg == 8'h00
		&& interrupt_enable_reg == 8'h00 && line_control_reg == 8'h00
		&& fifo_control_reg == 8'h00)
		else $error("control registers not cleared");
	AST_IRQ_QUIET: assert property (@(posedge ref_clk) disable iff (reset)
		int_status == 2'b00 |-> !irq)
		else $error("interrupt without status");
	AST_TRIG_INT: assert property (@(posedge ref_clk) disable iff (reset)
		trigger_hit && !trig_prev |=> int_status[1])
		else $error("trigger interrupt missed");
	AST_FEAT_RSVD: assert property (@(posedge ref_clk) disable iff (reset)
		enhanced_feature_reg[5:0] == 6'h00)
		else $error("reserved feature bits set");
	AST_WR_RESP: assert property (@(posedge ref_clk) disable iff (reset)
		aw_held && w_held |=> bvalid)
		else $error("write response missing");
	AST_B_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	AST_R_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
		rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read response dropped");
endmodule

// File: include/uart_msfc_pkg.sv
package uart_msfc_pkg;
	localparam logic [7:0] OFF_MODEM_STATUS = 8'h00;
	localparam logic [7:0] OFF_SCRATCH = 8'h04;
	localparam logic [7:0] OFF_FEATURE = 8'h08;
	localparam logic [7:0] OFF_MODEM_CONTROL = 8'h0c;
	localparam logic [7:0] OFF_INT_STATUS = 8'h10;
	localparam logic [7:0] OFF_INT_MASK = 8'h14;
	localparam logic [7:0] OFF_IDENT = 8'h18;
	localparam logic [7:0] OFF_LINE_STATUS = 8'h1c;
	localparam logic [7:0] OFF_INT_ENABLE = 8'h20;
	localparam logic [7:0] OFF_LINE_CONTROL = 8'h24;
	localparam logic [7:0] OFF_FIFO_CONTROL = 8'h28;
	localparam int FEAT_AUTO_CTS = 7;
	localparam int FEAT_AUTO_RTS = 6;
	localparam int MCR_DTR = 0;
	localparam int MCR_RTS = 1;
	localparam logic [7:0] FEATURE_RESERVED_MASK = 8'hc0;
	localparam logic [7:0] IDENT_RESET = 8'h01;
	localparam logic [7:0] LINE_STATUS_RESET = 8'h60;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam int EV_MODEM = 0;
	localparam int EV_TRIGGER = 1;
	typedef struct packed {
		logic dcd_n;
		logic ri_n;
		logic dsr_n;
		logic cts_n;
	} modem_in_t;
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
	} bus_word_t;
endpackage

// File: hdl/modem_delta.sv
`timescale 1ns/100ps
module modem_delta (
	input wire logic ref_clk,
	input wire logic reset,
	input wire uart_msfc_pkg::modem_in_t pins,
	input wire logic status_read,
	output logic [7:0] status
);
	uart_msfc_pkg::modem_in_t prev;
	logic [3:0] delta;
	logic [3:0] next_delta;
	logic [3:0] live;
	logic [3:0] pv;
	always_comb begin
		live = ~pins;
		pv = ~prev;
		next_delta = delta;
		if (status_read)
			next_delta = 4'h0;
		next_delta[0] = next_delta[0] | (live[0] ^ pv[0]);
		next_delta[1] = next_delta[1] | (live[1] ^ pv[1]);
		next_delta[2] = next_delta[2] | (live[2] & ~pv[2]);
		next_delta[3] = next_delta[3] | (live[3] ^ pv[3]);
	end
	always_ff @(posedge ref_clk) begin
		prev <= pins;
		if (reset)
			delta <= 4'h0;
		else
			delta <= next_delta;
	end
	// upper nibble is live even in reset
	assign status = {live[3], live[2], live[1], live[0], delta};
	AST_CTS_DELTA: assert property (@(posedge ref_clk) disable iff (reset)
		$changed(pins.cts_n) |=> status[0])
		else $error("cts change missed");
	AST_READ_CLEARS: assert property (@(posedge ref_clk) disable iff (reset)
		status_read && $stable(pins) |=> status[3:0] == 4'h0)
		else $error("read did not clear");
endmodule

// File: hdl/rts_flow.sv
`timescale 1ns/100ps
module rts_flow #(
	parameter int LEVEL_W = 7
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic auto_rts,
	input wire logic mcr_rts,
	input wire logic [LEVEL_W-1:0] rx_level,
	input wire logic [LEVEL_W-1:0] trig_level,
	input wire logic [LEVEL_W-1:0] next_trig_level,
	input wire logic [LEVEL_W-1:0] lower_trig_level,
	output logic trigger_hit,
	output logic rts_n
);
	// a one-bit level cannot tell three trigger points apart
	if (LEVEL_W < 2) begin : gen_level_check
		$error("level width too small");
	end
	logic held;
	logic next_held;
	always_comb begin
		next_held = held;
		if (!auto_rts)
			next_held = 1'b0;
		else if (rx_level >= next_trig_level)
			next_held = 1'b1;
		else if (rx_level < lower_trig_level)
			next_held = 1'b0;
	end
	always_ff @(posedge ref_clk) begin
		if (reset)
			held <= 1'b0;
		else
			held <= next_held;
	end
	assign trigger_hit = auto_rts && (rx_level >= trig_level);
	// pin is active low: deasserted means line high
	always_ff @(posedge ref_clk) begin
		if (reset)
			rts_n <= 1'b1;
		else if (auto_rts)
			rts_n <= next_held | ~mcr_rts;
		else
			rts_n <= ~mcr_rts;
	end
	AST_RTS_MANUAL: assert property (@(posedge ref_clk) disable iff (reset)
		!auto_rts |=> rts_n == ~$past(mcr_rts))
		else $error("rts not from modem control");
	AST_RTS_RELEASE: assert property (@(posedge ref_clk) disable iff (reset)
		auto_rts && mcr_rts && rx_level < lower_trig_level |=> !rts_n)
		else $error("rts not released");
	AST_RTS_STOP: assert property (@(posedge ref_clk) disable iff (reset)
		auto_rts && rx_level >= next_trig_level |=> rts_n)
		else $error("rts not raised");
endmodule

// File: test/modem_far_end.sv
`timescale 1ns/100ps
module modem_far_end (
	input wire logic ref_clk,
	input wire uart_msfc_pkg::modem_in_t want,
	input wire logic send_char,
	output uart_msfc_pkg::modem_in_t pins,
	output logic char_done
);
	// levels move only at edges, like an already synchronised modem
	always_ff @(posedge ref_clk) begin
		pins <= want;
		char_done <= send_char;
	end
endmodule

// File: test/uart_msfc_test.sv
`timescale 1ns/100ps
module uart_msfc_test;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rsp;
	uart_msfc_pkg::modem_in_t want = 4'h7, modem_pins;
	logic send_char = 1'b0;
	logic char_done;
	logic [6:0] rx_level = 7'h00, trig_level = 7'h08;
	logic [6:0] next_trig_level = 7'h10, lower_trig_level = 7'h04;
	logic tx_enable, tx_out, rts_n, dtr_n, irq;
	logic receive_ready_out, transmit_ready_out;
	logic [31:0] rv;
	int err_count = 0;
	int compares = 0;

	uart_msfc uart_msfc_inst (.ref_clk, .reset, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .modem_pins, .rx_level, .trig_level, .next_trig_level,
		.lower_trig_level, .char_done, .tx_enable, .tx_out, .rts_n,
		.dtr_n, .receive_ready_out, .transmit_ready_out, .irq);
	modem_far_end modem_far_end_inst (.ref_clk, .want, .send_char,
		.pins(modem_pins), .char_done);

	always #4 ref_clk = ~ref_clk;

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic final_report;
		$display("mismatches=%0d compares=%0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// a hung handshake is a fault in itself, so it ends the run
	task automatic give_up(input int n);
		if (n >= 50) begin
			err_count++;
			final_report();
		end
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		awaddr <= {24'h000000, a};
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		rsp = bresp;
		bready <= 1'b0;
		@(posedge ref_clk);
		give_up(n);
	endtask

	task automatic bus_rd(input logic [7:0] a);
		int n;
		araddr <= {24'h000000, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		rv = rdata;
		rsp = rresp;
		rready <= 1'b0;
		@(posedge ref_clk);
		give_up(n);
	endtask

	task automatic t_reset;
		logic [7:0] regs [5] = '{uart_msfc_pkg::OFF_FEATURE,
			uart_msfc_pkg::OFF_MODEM_CONTROL, uart_msfc_pkg::OFF_INT_ENABLE,
			uart_msfc_pkg::OFF_LINE_CONTROL, uart_msfc_pkg::OFF_FIFO_CONTROL};
		chk({tx_out, rts_n, dtr_n, receive_ready_out, transmit_ready_out,
			irq}, 32'h0000003c);
		bus_rd(uart_msfc_pkg::OFF_IDENT);
		chk(rv, 32'h00000001);
		bus_rd(uart_msfc_pkg::OFF_LINE_STATUS);
		chk(rv, 32'h00000060);
		bus_rd(uart_msfc_pkg::OFF_MODEM_STATUS);
		chk(rv, 32'h00000080);
		foreach (regs[i]) begin
			bus_rd(regs[i]);
			chk(rv, 32'h00000000);
		end
	endtask

	task automatic t_scratch;
		bus_wr(uart_msfc_pkg::OFF_SCRATCH, 8'ha5);
		bus_rd(uart_msfc_pkg::OFF_SCRATCH);
		chk(rv, 32'h000000a5);
		chk({rts_n, tx_out}, 32'h00000003);
		bus_wr(8'h40, 8'h11);
		chk(rsp, uart_msfc_pkg::RESP_SLVERR);
		bus_rd(8'h40);
		chk(rsp, uart_msfc_pkg::RESP_SLVERR);
	endtask

	task automatic t_modem;
		bus_wr(uart_msfc_pkg::OFF_INT_MASK, 8'h01);
		bus_rd(uart_msfc_pkg::OFF_INT_STATUS);
		want <= 4'h4;
		tick(4);
		chk(irq, 1'b1);
		bus_rd(uart_msfc_pkg::OFF_MODEM_STATUS);
		chk(rv, 32'h000000b3);
		bus_rd(uart_msfc_pkg::OFF_MODEM_STATUS);
		chk(rv, 32'h000000b0);
		bus_rd(uart_msfc_pkg::OFF_INT_STATUS);
		chk(rv, 32'h00000001);
		tick(2);
		chk(irq, 1'b0);
		bus_wr(uart_msfc_pkg::OFF_INT_MASK, 8'h00);
		want <= 4'h5;
		tick(4);
		chk(irq, 1'b0);
		bus_rd(uart_msfc_pkg::OFF_MODEM_STATUS);
		chk(rv, 32'h000000a1);
		bus_rd(uart_msfc_pkg::OFF_INT_STATUS);
		chk(rv, 32'h00000001);
		bus_wr(uart_msfc_pkg::OFF_INT_MASK, 8'h03);
	endtask

	task automatic t_rts;
		bus_wr(uart_msfc_pkg::OFF_MODEM_CONTROL, 8'h02);
		rx_level <= 7'h20;
		tick(3);
		chk(rts_n, 1'b0);
		rx_level <= 7'h00;
		bus_wr(uart_msfc_pkg::OFF_FEATURE, 8'h40);
		bus_rd(uart_msfc_pkg::OFF_INT_STATUS);
		rx_level <= 7'h08;
		tick(3);
		chk({rts_n, irq}, 32'h00000001);
		bus_rd(uart_msfc_pkg::OFF_INT_STATUS);
		chk(rv, 32'h00000002);
		rx_level <= 7'h10;
		tick(3);
		chk(rts_n, 1'b1);
		rx_level <= 7'h04;
		tick(3);
		chk(rts_n, 1'b1);
		rx_level <= 7'h03;
		tick(3);
		chk(rts_n, 1'b0);
		bus_rd(uart_msfc_pkg::OFF_INT_STATUS);
		bus_wr(uart_msfc_pkg::OFF_FEATURE, 8'hff);
		bus_rd(uart_msfc_pkg::OFF_FEATURE);
		chk(rv, 32'h000000c0);
		bus_wr(uart_msfc_pkg::OFF_FEATURE, 8'h00);
		bus_wr(uart_msfc_pkg::OFF_MODEM_CONTROL, 8'h01);
		tick(2);
		chk({rts_n, dtr_n}, 32'h00000002);
	endtask

	task automatic t_cts;
		tick(2);
		chk(tx_enable, 1'b1);
		bus_wr(uart_msfc_pkg::OFF_FEATURE, 8'h80);
		send_char <= 1'b1;
		tick(1);
		send_char <= 1'b0;
		tick(3);
		chk(tx_enable, 1'b0);
		want <= 4'h4;
		tick(4);
		chk(tx_enable, 1'b1);
		bus_rd(uart_msfc_pkg::OFF_INT_STATUS);
	endtask

	initial begin
		tick(12);
		reset <= 1'b0;
		t_reset();
		t_scratch();
		t_modem();
		t_rts();
		t_cts();
		final_report();
	end
endmodule
